/* shared/sacc_pkg.sv */
// Behaviour
// - First step sets MSB if input at or above half
// - Next bit set, tap quarter or three-quarter
// - Keep trial bit if input at or above
// - Stop at bit 0, or bit 2 for 8-bit
// - Copy approximation into results once per conversion
// - Ten-bit result left justified, low six zero
// - Upper eight result bits into byte register
// - Interrupt only after all setup conversions finish
// - Interrupt issued through upper/lower limit comparator
// - Positive reference select 01 picks external pin
// - Negative select 1 picks external pin, else ground
// - Gate bit zero stops clock, holds reset
// - Gate zero forces converter initial values, ignores writes; pin configuration stays writable
// - Gate bit one supplies clock, allows access
// - Enable register resets zero, unused bits zero
// - Unselected analog pins stay general port pins unless set in pin configuration
// - Gain amplifier output selectable as input
// - Sample-and-hold keeps voltage during approximation
package sacc_pkg;

    // Register byte addresses
    localparam logic [19:0] ADDR_CTRL    = 20'h00000;
    localparam logic [19:0] ADDR_LIMITS  = 20'h00004;
    localparam logic [19:0] ADDR_RES16   = 20'h00008;
    localparam logic [19:0] ADDR_RES8    = 20'h0000C;
    localparam logic [19:0] ADDR_STATUS  = 20'h00010;
    localparam logic [19:0] ADDR_SETUP   = 20'h00014;
    localparam logic [19:0] ADDR_PINCFG  = 20'h00018;
    localparam logic [19:0] ADDR_PERIPHERAL_CLOCK_ENABLE_0    = 20'hF00F0;

    // Peripheral enable register fields
    localparam int          PERIPHERAL_CLOCK_ENABLE_0_GATE_BIT = 5;
    localparam logic [7:0]  PERIPHERAL_CLOCK_ENABLE_0_RESET    = 8'h00;
    localparam logic [7:0]  PERIPHERAL_CLOCK_ENABLE_0_USED     = 8'h25;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RES8_BIT  = 1;
    localparam int CTRL_PREF_LO   = 2;
    localparam int CTRL_PREF_HI   = 3;
    localparam int CTRL_NREF_BIT  = 4;
    localparam int CTRL_PGA_BIT   = 5;
    localparam int CTRL_CH_LSB    = 8;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;

    // Register reset values
    localparam logic [7:0]  UPPER_RESET  = 8'hFF;
    localparam logic [7:0]  LOWER_RESET  = 8'h00;
    localparam logic [15:0] RES16_RESET  = 16'h0000;
    localparam logic [7:0]  RES8_RESET   = 8'h00;
    localparam logic [3:0]  SETUP_RESET  = 4'h1;
    localparam logic [11:0] PINCFG_RESET = 12'h000;

    // Conversion timing
    localparam int          CLK_MHZ      = 125;
    localparam int          STEP_NS      = 32;
    localparam int          STEP_DIV     = (STEP_NS * CLK_MHZ) / 1000;
    localparam logic [3:0]  SAMPLE_STEPS = 4'h5;

    // Approximation register layout
    localparam logic [9:0]  SAR_MSB      = 10'h200;
    localparam logic [3:0]  BIT_LAST_10  = 4'h0;
    localparam logic [3:0]  BIT_LAST_8   = 4'h2;
    localparam logic [3:0]  BIT_TOP      = 4'h9;
    localparam logic [3:0]  CH_COUNT     = 4'hC;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_APPROX,
        ST_STORE
    } sacc_state_t;

    // Signals toward the analog front end
    typedef struct packed {
        logic [3:0] channel;       // Selected analog input
        logic       gain_amp_sel;  // Gain amplifier output as input
        logic       pos_ref_ext;   // External positive reference pin
        logic       pos_ref_int;   // Internal reference
        logic       pos_ref_vdd;   // Supply as positive reference
        logic       neg_ref_ext;   // External negative reference pin
        logic       sample_hold;   // Hold sampled voltage
        logic       sampling;      // Track the input
        logic [9:0] tap_code;      // Comparison tap
    } sacc_analog_t;

endpackage : sacc_pkg

/* core/sacc_core.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module sacc_core (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [19:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Comparator decision, synchronous
    input  wire logic                  comp_ge,
    // Analog front end control
    output sacc_pkg::sacc_analog_t     analog_ctrl,
    output logic                       converter_clk_en,
    output logic                       converter_reset,
    output logic [11:0]                port_pin_enable,
    // Conversion end request
    output logic                       conversion_end_irq
);
    import sacc_pkg::*;

    // Register state
    logic [7:0]   peripheral_clock_enable_0_q;          // Peripheral enable register
    logic [15:0]  ctrl_q;          // Converter control
    logic [7:0]   upper_q;         // Upper limit
    logic [7:0]   lower_q;         // Lower limit
    logic [3:0]   setup_q;         // Conversions per setup
    logic [11:0]  pincfg_q;        // Analog pin configuration
    logic [15:0]  res16_q;         // result_ten_bit
    logic [7:0]   res8_q;          // result_eight_bit
    logic         in_range_q;      // Last limit comparison
    logic         pready_q;        // Access phase answer
    logic [31:0]  prdata_q;        // Read data
    logic         pslverr_q;       // Error answer
    logic         irq_q;           // Interrupt pulse

    // Sequencer state
    sacc_state_t  state_q;
    sacc_state_t  state_d;
    logic [9:0]   sar_q;           // successive_approx_reg
    logic [9:0]   sar_d;
    logic [3:0]   idx_q;           // Bit under trial
    logic [3:0]   idx_d;
    logic [3:0]   cnt_q;           // Sample steps remaining
    logic [3:0]   cnt_d;
    logic [3:0]   done_q;          // Conversions finished in setup
    logic [7:0]   div_q;           // Conversion step divider
    logic         store_q;         // One-cycle store pulse

    // Gate bit and bus decode
    wire          gate      = peripheral_clock_enable_0_q[PERIPHERAL_CLOCK_ENABLE_0_GATE_BIT];
    wire          access    = psel & penable;
    wire          wr_en     = access & pready_q & pwrite;
    wire          hit_ctrl  = (paddr == ADDR_CTRL);
    wire          hit_lim   = (paddr == ADDR_LIMITS);
    wire          hit_r16   = (paddr == ADDR_RES16);
    wire          hit_r8    = (paddr == ADDR_RES8);
    wire          hit_stat  = (paddr == ADDR_STATUS);
    wire          hit_setup = (paddr == ADDR_SETUP);
    wire          hit_pin   = (paddr == ADDR_PINCFG);
    wire          hit_peripheral_clock_enable_0  = (paddr == ADDR_PERIPHERAL_CLOCK_ENABLE_0);
    wire          mapped    = hit_ctrl | hit_lim | hit_r16 | hit_r8 |
                              hit_stat | hit_setup | hit_pin | hit_peripheral_clock_enable_0;
    // Converter writes refused while gated off
    wire          cvt_wr    = wr_en & gate;
    wire          start_wr  = cvt_wr & hit_ctrl & pstrb[0] &
                              pwdata[CTRL_START_BIT];
    wire          busy      = (state_q != ST_IDLE);

    // Step enable from the divider
    wire          step      = (div_q == 8'(STEP_DIV - 1));

    // Last bit depends on resolution
    wire [3:0]    last_bit  = ctrl_q[CTRL_RES8_BIT] ? BIT_LAST_8
                                                    : BIT_LAST_10;

    // Limit comparator on the upper eight result bits
    wire [7:0]    new_res8  = sar_q[9:2];
    wire          new_in_rng = (new_res8 <= upper_q) &&
                               (new_res8 >= lower_q);

    // Byte-lane merge for writes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        merge16 = {st[1] ? wd[15:8] : old[15:8],
                   st[0] ? wd[7:0]  : old[7:0]};
    endfunction

    // Read data mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_peripheral_clock_enable_0) begin
            rd_mux = {24'h000000, peripheral_clock_enable_0_q};
        end else if (hit_ctrl) begin
            rd_mux = {16'h0000, ctrl_q[15:1], busy};
        end else if (hit_lim) begin
            rd_mux = {16'h0000, lower_q, upper_q};
        end else if (hit_r16) begin
            rd_mux = {16'h0000, res16_q};
        end else if (hit_r8) begin
            rd_mux = {24'h000000, res8_q};
        end else if (hit_stat) begin
            rd_mux = {27'h0000000, state_q, done_q == 4'h0,
                      in_range_q, busy};
        end else if (hit_setup) begin
            rd_mux = {28'h0000000, setup_q};
        end else if (hit_pin) begin
            rd_mux = {20'h00000, pincfg_q};
        end
    end

    // APB answer: one wait state, then ready with data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access & ~pready_q;
            prdata_q  <= rd_mux;
            pslverr_q <= access & ~pready_q & ~mapped;
        end
    end

    // Peripheral enable register, always writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_clock_enable_0_q <= PERIPHERAL_CLOCK_ENABLE_0_RESET;
        end else if (wr_en & hit_peripheral_clock_enable_0 & pstrb[0]) begin
            peripheral_clock_enable_0_q <= pwdata[7:0] & PERIPHERAL_CLOCK_ENABLE_0_USED;
        end
    end

    // Pin configuration stays writable while gated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pincfg_q <= PINCFG_RESET;
        end else if (wr_en & hit_pin) begin
            pincfg_q <= 12'(merge16({4'h0, pincfg_q}, pwdata, pstrb));
        end
    end

    // Converter setup registers, forced while gated off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RESET;
            upper_q <= UPPER_RESET;
            lower_q <= LOWER_RESET;
            setup_q <= SETUP_RESET;
        end else if (!gate) begin
            ctrl_q  <= CTRL_RESET;
            upper_q <= UPPER_RESET;
            lower_q <= LOWER_RESET;
            setup_q <= SETUP_RESET;
        end else begin
            if (cvt_wr & hit_ctrl) begin
                ctrl_q <= merge16(ctrl_q, pwdata, pstrb);
            end
            if (cvt_wr & hit_lim) begin
                {lower_q, upper_q} <= merge16({lower_q, upper_q},
                                              pwdata, pstrb);
            end
            if (cvt_wr & hit_setup & pstrb[0]) begin
                setup_q <= pwdata[3:0];
            end
        end
    end

    // Conversion step divider, runs only with the gate set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
        end else if (!gate || !busy || step) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        sar_d   = sar_q;
        idx_d   = idx_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE: begin
                // Start loads the sample step count
                if (start_wr) begin
                    state_d = ST_SAMPLE;
                    cnt_d   = SAMPLE_STEPS;
                end
            end
            ST_SAMPLE: begin
                // Track input for the sampling steps
                if (step) begin
                    if (cnt_q == 4'h1) begin
                        state_d = ST_APPROX;
                        sar_d   = SAR_MSB;
                        idx_d   = BIT_TOP;
                    end else begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
            end
            ST_APPROX: begin
                // One trial bit decided per step
                if (step) begin
                    sar_d[idx_q] = comp_ge;
                    if (idx_q == last_bit) begin
                        state_d = ST_STORE;
                    end else begin
                        sar_d[idx_q - 4'h1] = 1'b1;
                        idx_d = idx_q - 4'h1;
                    end
                end
            end
            ST_STORE: begin
                // Result copied this cycle, next or stop
                if (done_q + 4'h1 >= setup_q) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_SAMPLE;
                    cnt_d   = SAMPLE_STEPS;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers, held in reset while gated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            sar_q   <= 10'h000;
            idx_q   <= 4'h0;
            cnt_q   <= 4'h0;
        end else if (!gate) begin
            state_q <= ST_IDLE;
            sar_q   <= 10'h000;
            idx_q   <= 4'h0;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            sar_q   <= sar_d;
            idx_q   <= idx_d;
            cnt_q   <= cnt_d;
        end
    end

    // Results, conversion count and limit check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res16_q    <= RES16_RESET;
            res8_q     <= RES8_RESET;
            in_range_q <= 1'b0;
            done_q     <= 4'h0;
            store_q    <= 1'b0;
        end else if (!gate) begin
            res16_q    <= RES16_RESET;
            res8_q     <= RES8_RESET;
            in_range_q <= 1'b0;
            done_q     <= 4'h0;
            store_q    <= 1'b0;
        end else begin
            store_q <= (state_q == ST_STORE);
            if (state_q == ST_STORE) begin
                res16_q    <= {sar_q, 6'h00};
                res8_q     <= new_res8;
                in_range_q <= new_in_rng;
                done_q     <= (state_d == ST_IDLE) ? 4'h0
                                                   : done_q + 4'h1;
            end else if (start_wr) begin
                done_q <= 4'h0;
            end
        end
    end

    // End request after the whole setup, via the limit result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= gate & store_q & ~busy & in_range_q;
        end
    end

    // Analog control, registered
    sacc_analog_t analog_d;
    always_comb begin
        analog_d              = '0;
        analog_d.channel      = ctrl_q[CTRL_CH_LSB +: 4];
        analog_d.gain_amp_sel = ctrl_q[CTRL_PGA_BIT];
        // Positive reference: 01 pin, 10 internal, else supply
        analog_d.pos_ref_ext  = ~ctrl_q[CTRL_PREF_HI] &
                                ctrl_q[CTRL_PREF_LO];
        analog_d.pos_ref_int  = ctrl_q[CTRL_PREF_HI] &
                                ~ctrl_q[CTRL_PREF_LO];
        analog_d.pos_ref_vdd  = ~(analog_d.pos_ref_ext |
                                  analog_d.pos_ref_int);
        analog_d.neg_ref_ext  = ctrl_q[CTRL_NREF_BIT];
        analog_d.sampling     = (state_d == ST_SAMPLE);
        analog_d.sample_hold  = (state_d == ST_APPROX);
        analog_d.tap_code     = sar_d;
    end

    // Pin ownership: selected analog pin leaves the port while busy, unless the gain amplifier is selected
    logic [11:0] port_d;
    always_comb begin
        port_d = ~pincfg_q;
        if (busy && !ctrl_q[CTRL_PGA_BIT] &&
            ctrl_q[CTRL_CH_LSB +: 4] < CH_COUNT) begin
            port_d[ctrl_q[CTRL_CH_LSB +: 4]] = 1'b0;
        end
    end

    // Output registers toward the analog side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctrl     <= '0;
            port_pin_enable <= 12'hFFF;
        end else begin
            analog_ctrl     <= gate ? analog_d : '0;
            port_pin_enable <= port_d;
        end
    end

    // Port drives
    assign pready             = pready_q;
    assign prdata             = prdata_q;
    assign pslverr            = pslverr_q;
    assign converter_clk_en   = gate;
    assign converter_reset    = ~gate;
    assign conversion_end_irq = irq_q;

endmodule // sacc_core

/* dv/sacc_afe_model.sv */
`timescale 1ns/10ps
module sacc_afe_model (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Front end control and test voltage
    input  wire sacc_pkg::sacc_analog_t analog_ctrl,
    input  wire logic [9:0]             vin,
    // Comparator decision
    output logic                        comp_ge
);
    import sacc_pkg::*;
    logic [9:0] held_q;   // Voltage kept by the hold stage
    logic       noise_q;  // Toggles so a stale decision never looks valid
    // Track while sampling, freeze while holding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q  <= 10'h000;
            noise_q <= 1'b0;
        end else begin
            noise_q <= !noise_q;
            if (analog_ctrl.sampling && !analog_ctrl.sample_hold) begin
                held_q <= vin;
            end
        end
    end
    // Ideal comparator: input at or above the tap
    assign comp_ge = analog_ctrl.sample_hold ?
                     (held_q >= analog_ctrl.tap_code) : noise_q;
endmodule // sacc_afe_model

/* dv/sacc_core_checker.sv */
`timescale 1ns/10ps
module sacc_core_checker (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // Register bus
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [19:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    // Converter side
    input wire logic                   comp_ge,
    input wire sacc_pkg::sacc_analog_t analog_ctrl,
    input wire logic                   converter_clk_en,
    input wire logic                   converter_reset,
    input wire logic [11:0]            port_pin_enable,
    input wire logic                   conversion_end_irq
);
    import sacc_pkg::*;
    logic [9:0] tap_q;   // Tap of the previous cycle
    logic       hold_q;  // Hold flag of the previous cycle
    wire  [9:0] trial = tap_q & (~tap_q + 10'h001); // Bit under trial
    wire        rd_ok = pready && !pwrite && !pslverr; // Good read answer
    // Remember the previous tap and hold flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_q  <= 10'h000;
            hold_q <= 1'b0;
        end else begin
            tap_q  <= analog_ctrl.tap_code;
            hold_q <= analog_ctrl.sample_hold;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A trial decision in the middle of the sequence
    sequence trial_step;
        $changed(analog_ctrl.tap_code) && analog_ctrl.sample_hold && hold_q
            && trial >= 10'h008;
    endsequence
    gate_level_a: assert property (converter_clk_en == !converter_reset)
        else $error("gate and reset disagree");
    gate_write_a: assert property (pready && pwrite && !pslverr &&
        paddr == ADDR_PERIPHERAL_CLOCK_ENABLE_0 && pstrb[0] |=>
        converter_clk_en == $past(pwdata[5])) else $error("gate not set");
    first_tap_a: assert property ($rose(analog_ctrl.sample_hold) |->
        analog_ctrl.tap_code == SAR_MSB) else $error("first tap wrong");
    trial_next_a: assert property (trial_step |-> analog_ctrl.tap_code ==
        (($past(comp_ge) ? tap_q : tap_q & ~trial) | (trial >> 1)))
        else $error("trial decision wrong");
    step_gap_a: assert property (trial_step |=>
        $stable(analog_ctrl.tap_code) [*3]) else $error("step too short");
    irq_idle_a: assert property (conversion_end_irq |->
        !analog_ctrl.sampling && !analog_ctrl.sample_hold)
        else $error("irq during conversion");
    irq_pulse_a: assert property (conversion_end_irq |=> !conversion_end_irq)
        else $error("irq longer than a cycle");
    gated_idle_a: assert property (!converter_clk_en &&
        !$past(converter_clk_en) |-> !analog_ctrl.sampling &&
        !analog_ctrl.sample_hold && !conversion_end_irq)
        else $error("gated converter active");
    pin_release_a: assert property (analog_ctrl.sampling &&
        $past(analog_ctrl.sampling) && !analog_ctrl.gain_amp_sel |->
        !port_pin_enable[analog_ctrl.channel]) else $error("pin still port");
    ref_onehot_a: assert property ($onehot0({analog_ctrl.pos_ref_ext,
        analog_ctrl.pos_ref_int, analog_ctrl.pos_ref_vdd}))
        else $error("two references at once");
    res16_low_a: assert property (rd_ok && paddr == ADDR_RES16 |->
        prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000)
        else $error("result low bits set");
    peripheral_clock_enable_0_unused_a: assert property (rd_ok && paddr == ADDR_PERIPHERAL_CLOCK_ENABLE_0 |->
        (prdata & ~32'h00000025) == 32'h0) else $error("unused bits set");
endmodule // sacc_core_checker
bind sacc_core sacc_core_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comp_ge(comp_ge), .analog_ctrl(analog_ctrl),
    .converter_clk_en(converter_clk_en), .converter_reset(converter_reset),
    .port_pin_enable(port_pin_enable),
    .conversion_end_irq(conversion_end_irq));

/* dv/sacc_core_bench.sv */
`timescale 1ns/10ps
module sacc_core_bench;
    import sacc_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
    // Expected answer of one bus transfer
    typedef struct packed {
        logic [31:0] d;  // Expected read data
        logic [31:0] m;  // Bits that are compared
        logic        e;  // Expected error flag
    } sacc_note_t;
    logic         pclk = 1'b0;      // Bus clock
    logic         presetn = 1'b0;   // Reset, active low
    logic         psel = 1'b0;      // Bus request
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [19:0]  paddr = 20'h00000;
    logic [31:0]  pwdata = 32'h0;
    logic         pready, pslverr, comp_ge, converter_clk_en;
    logic         converter_reset, conversion_end_irq;
    logic [31:0]  prdata;
    logic [11:0]  port_pin_enable;
    logic [9:0]   vin = 10'h000;    // Test voltage at the input
    sacc_analog_t analog_ctrl;
    sacc_note_t   notes[$];         // Answers still awaited
    sacc_note_t   cur;              // Answer being compared
    int           num_errors = 0;
    int           total_checks = 0;
    int           irqs = 0;         // Interrupt pulses seen
    // Free running bus clock
    always #4 pclk = ~pclk;
    sacc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .comp_ge(comp_ge), .analog_ctrl(analog_ctrl),
        .converter_clk_en(converter_clk_en),
        .converter_reset(converter_reset),
        .port_pin_enable(port_pin_enable),
        .conversion_end_irq(conversion_end_irq));
    sacc_afe_model afe (.pclk(pclk), .presetn(presetn),
        .analog_ctrl(analog_ctrl), .vin(vin), .comp_ge(comp_ge));
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One bus transfer, held until the answer comes
    task automatic apb(input logic [19:0] a, input logic w,
                       input logic [31:0] d, input sacc_note_t n,
                       output logic [31:0] r);
        int k;
        notes.push_back(n);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask
    // Write with no expected data
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, '{32'h0, 32'h0, 1'b0}, r);
    endtask
    // Read with full compare
    task automatic rd(input logic [19:0] a, input logic [31:0] x,
                      input logic e);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0, '{x, 32'hFFFFFFFF, e}, r);
    endtask
    // Answer watcher: oldest note against each answer
    always @(posedge pclk) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            cur = notes.pop_front();
            `CHK(prdata & cur.m, cur.d & cur.m)
            `CHK(pslverr, cur.e)
        end
        if (conversion_end_irq === 1'b1) irqs++;
    end
    // Start one conversion, wait for idle, compare results
    task automatic conv(input logic [9:0] v, input logic [4:0] mode,
                        input logic [3:0] ch, input int nirq);
        logic [31:0] r;
        logic [9:0]  x;
        int          k;
        int          i0;
        x = mode[0] ? (v & 10'h3FC) : v;
        i0 = irqs;
        @(posedge pclk) vin <= v;
        wr(ADDR_CTRL, {20'h0, ch, 2'b00, mode, 1'b1});
        repeat (3) @(posedge pclk);
        `CHK(analog_ctrl.pos_ref_ext, mode[2:1] == 2'b01)
        `CHK(analog_ctrl.neg_ref_ext, mode[3])
        `CHK(analog_ctrl.gain_amp_sel, mode[4])
        `CHK(port_pin_enable[ch], mode[4])
        k = 0;
        do begin
            apb(ADDR_CTRL, 1'b0, 32'h0, '{32'h0, 32'h0, 1'b0}, r);
            k++;
        end while (r[0] !== 1'b0 && k < 60);
        `CHK(r[0], 1'b0)
        if (r[0] !== 1'b0) complete_run();
        rd(ADDR_RES16, {16'h0, x, 6'h00}, 1'b0);
        rd(ADDR_RES8, {24'h0, x[9:2]}, 1'b0);
        repeat (4) @(posedge pclk);
        `CHK(irqs - i0, nirq)
    endtask
    // Main sequence
    initial begin
        logic [9:0] v;
        void'($urandom(32'hBE96940B));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h0, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h0, 1'b0);
        `CHK(converter_reset, 1'b1)
        wr(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'hFF);
        rd(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h25, 1'b0);
        `CHK(converter_clk_en, 1'b1)
        wr(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h20);
        rd(20'h00100, 32'h0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = 10'($urandom);
            if (i == 0) v = 10'h3FF;
            if (i == 1) v = 10'h000;
            conv(v, {2'($urandom), 3'(i)}, 4'($urandom % 12), 1);
        end
        wr(ADDR_SETUP, 32'h2);
        conv(10'h155, 5'h00, 4'hB, 1);
        wr(ADDR_SETUP, 32'h1);
        wr(ADDR_LIMITS, 32'h0);
        conv(10'h3FF, 5'h00, 4'h1, 0);
        conv(10'h000, 5'h01, 4'h2, 1);
        wr(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h0);
        rd(ADDR_RES16, 32'h0, 1'b0);
        rd(ADDR_RES8, 32'h0, 1'b0);
        `CHK(converter_reset, 1'b1)
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h0, 1'b0);
        complete_run();
    end
endmodule // sacc_core_bench
